//--- logic/bsr_pkg.sv
// Constants and carrier types shared by the board system register bank
package bsr_pkg;

  // ----------------------------------------------------------------
  // I/O addresses of the registers
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_FLASH = 16'h0078; // Flash page and boot control
  localparam logic [15:0] ADDR_WDOG  = 16'h0079; // Watchdog control
  localparam logic [15:0] ADDR_SELFTEST_PROGRESS  = 16'h0080; // Self-test progress code
  localparam logic [15:0] ADDR_STAT  = 16'h00E1; // Enum, stage-1 and supply status
  localparam logic [15:0] ADDR_BID   = 16'h00E2; // Board identity
  localparam logic [15:0] ADDR_SWMON = 16'h00E3; // Switch monitors
  localparam logic [15:0] ADDR_NET   = 16'h00E4; // Network and slot addressing
  localparam logic [15:0] ADDR_VIDEO = 16'h00E5; // Video and indicator control
  localparam logic [15:0] ADDR_HIDX  = 16'h00E6; // Host function index
  localparam logic [15:0] ADDR_HDATA = 16'h00E7; // Host function data
  localparam logic [15:0] ADDR_INT   = 16'h00E8; // Interrupt status and mask

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FLASH = 8'h00; // Flash control after init
  localparam logic [7:0] RST_REG   = 8'h00; // Every other plain register
  localparam logic [3:0] RST_IMASK = 4'h4;  // Mask half of the interrupt register
  localparam logic [7:0] RD_FLOAT  = 8'hFF; // Answer for an unmapped read

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          FL_OVR_BIT  = 7;      // Boot-source override
  localparam int          FL_PAGE_LSB = 4;      // Page select, bits 6..4
  localparam int          FL_PAGE_W   = 3;      // Width of page select
  localparam int          FL_SCR_BIT  = 2;      // Scratch bit
  localparam int          FL_WE_BIT   = 1;      // Flash write enable
  localparam logic [7:0]  FL_WMASK    = 8'hF6;  // Bits that hold a value
  localparam int          ST_ENUM_BIT = 0;      // Enumeration state
  localparam int          ST_NMI_BIT  = 1;      // Watchdog stage-1 timeout
  localparam int          ST_PSU_BIT  = 2;      // Power supply status
  localparam int          INT_MASK_W  = 4;      // Mask bits 3..0, status 7..4
  localparam int          HC_IDX_W    = 3;      // Index bits that select data
  localparam int          HC_N        = 8;      // Host function data entries
  localparam int          SENSE_W     = 16;     // Width of the sensed pin group

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;     // Write strobe, one cycle
    logic        rd;     // Read strobe, one cycle
    logic [15:0] addr;   // I/O address
    logic [7:0]  wdata;  // Write data
  } bsr_io_req_t;

  typedef struct packed {
    logic       boot_sw;     // Boot-source switch, 1 = onboard flash
    logic       enum_state;  // Enumeration state
    logic       wd_stage1;   // Watchdog stage-1 timeout seen
    logic       psu_ok;      // Power supply status
    logic [7:0] switches;    // Switch monitor inputs
    logic [3:0] int_status;  // Raw interrupt status
  } bsr_sense_t;

  typedef struct packed {
    logic [7:0] wdog;      // Watchdog control byte
    logic [7:0] selftest_progress;      // Latched self-test progress code
    logic [7:0] board_identity;  // Board identity byte
    logic [7:0] net;       // Network and slot addressing byte
    logic [7:0] video;     // Video and indicator byte
    logic [7:0] hidx;      // Host function index
    logic [3:0] imask;     // Interrupt mask bits
  } bsr_ctl_t;

endpackage

//--- logic/bsr_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module bsr_sync #(
  parameter int W = 16  // Number of bits synchronised
) (
  input  wire logic         ref_clk, // System clock
  input  wire logic         rst,     // Synchronous reset, active high
  input  wire logic [W-1:0] din,     // Asynchronous pin levels
  output logic      [W-1:0] dout     // Filtered, registered levels
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;  // First stage, read only by the second
    logic [W-1:0] s2;  // Second stage
    logic [W-1:0] s3;  // Third stage
    logic [W-1:0] q;   // Accepted value
  } bsr_sync_st_t;

  bsr_sync_st_t st_q;  // Registered state
  bsr_sync_st_t st_d;  // Next state
  logic [W-1:0] acc;   // Per-bit accepted next value

  // ----------------------------------------------------------------
  // Per-bit filter: accept only when stages two and three agree
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign acc[i] = (st_q.s2[i] == st_q.s3[i]) ? st_q.s3[i] : st_q.q[i];
  end

  // Shift chain and accepted value
  always_comb begin
    st_d    = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.q  = acc;
  end

  // Register the whole state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.q;

endmodule

//--- logic/bsr_top.sv
// Board system register bank on the processor I/O port
//
// What this block does
// - Byte registers decoded at fixed I/O addresses
// - Flash control clears on init or reset
// - Bit 7 overrides boot switch, forces flash
// - Bits 6..4 drive flash lines A24..A22
// - Page zero after reset exposes firmware
// - Bit 2 is a plain scratch bit
// - Status register read-only, writes ignored
// - Interrupt register mixes status, mask; 04h
// - Index selects what data register reaches
`timescale 1ns/1ps

module bsr_top (
  input  wire logic                ref_clk,        // System clock, 100 MHz
  input  wire logic                rst,            // Board init/reset, active high
  input  wire bsr_pkg::bsr_io_req_t io_req,        // I/O cycle from the processor
  output logic [7:0]               io_rdata,       // Read data, registered
  output logic                     io_rack,        // Read answer pulse
  input  wire bsr_pkg::bsr_sense_t sense_in,       // Asynchronous board pins
  input  wire logic                flash_we_req_n, // Flash write request, low
  output logic                     flash_we_n,     // Gated flash write, low
  output logic [2:0]               flash_page,     // Flash A24..A22
  output logic                     boot_from_flash,// Boot from onboard flash
  output bsr_pkg::bsr_ctl_t        ctl_out         // Control register contents
);
  import bsr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]            flash;  // Flash page and boot control
    logic [7:0]            wdog;   // Watchdog control
    logic [7:0]            selftest_progress;   // Self-test progress code
    logic [7:0]            bid;    // Board identity
    logic [7:0]            net;    // Network and slot addressing
    logic [7:0]            video;  // Video and indicator control
    logic [7:0]            hidx;   // Host function index
    logic [HC_N-1:0][7:0]  hdata;  // Host function data entries
    logic [INT_MASK_W-1:0] imask;  // Interrupt mask bits
    logic [7:0]            rdata;  // Read data holding register
    logic                  rack;   // Read answer
  } bsr_st_t;

  bsr_st_t    st_q;      // Registered state
  bsr_st_t    st_d;      // Next state
  bsr_sense_t sns;       // Synchronised pins
  logic [7:0] stat_val;  // Live status byte
  logic [7:0] int_val;   // Live interrupt byte
  logic [7:0] rd_val;    // Selected read value
  logic       mapped;    // Address hits a register

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // All sensed pins come from off-board switches or other logic with
  // no clock relation, so they pass the filter together.
  bsr_sync #(
    .W (SENSE_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (sense_in),
    .dout    (sns)
  );

  // ----------------------------------------------------------------
  // Status bytes built from synchronised pins
  // ----------------------------------------------------------------
  // Status is never stored; it reflects pins as they stand.
  always_comb begin
    stat_val              = 8'h00;
    stat_val[ST_ENUM_BIT] = sns.enum_state;
    stat_val[ST_NMI_BIT]  = sns.wd_stage1;
    stat_val[ST_PSU_BIT]  = sns.psu_ok;
  end

  // Upper nibble is live status, lower nibble the stored mask
  assign int_val = {sns.int_status, st_q.imask};

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    if (io_req.addr == ADDR_FLASH) begin
      rd_val = st_q.flash;                    // Reserved bits held at 0
    end else if (io_req.addr == ADDR_WDOG) begin
      rd_val = st_q.wdog;
    end else if (io_req.addr == ADDR_SELFTEST_PROGRESS) begin
      rd_val = 8'h00;                         // Code is write only
    end else if (io_req.addr == ADDR_STAT) begin
      rd_val = stat_val;
    end else if (io_req.addr == ADDR_BID) begin
      rd_val = st_q.bid;
    end else if (io_req.addr == ADDR_SWMON) begin
      rd_val = sns.switches;
    end else if (io_req.addr == ADDR_NET) begin
      rd_val = st_q.net;
    end else if (io_req.addr == ADDR_VIDEO) begin
      rd_val = st_q.video;
    end else if (io_req.addr == ADDR_HIDX) begin
      rd_val = st_q.hidx;
    end else if (io_req.addr == ADDR_HDATA) begin
      rd_val = st_q.hdata[st_q.hidx[HC_IDX_W-1:0]];
    end else if (io_req.addr == ADDR_INT) begin
      rd_val = int_val;
    end else begin
      // No register answers; io_rack still pulses and the data floats high
      rd_val = RD_FLOAT;
      mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic: writes and read capture
  // ----------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.rack = io_req.rd;
    // Read data holds until the next read
    if (io_req.rd) begin
      st_d.rdata = rd_val;
    end
    if (io_req.wr) begin
      if (io_req.addr == ADDR_FLASH) begin
        // Reserved bits 3 and 0 are dropped, so a careless write
        // cannot leave a stray one behind
        st_d.flash = io_req.wdata & FL_WMASK;
      end else if (io_req.addr == ADDR_WDOG) begin
        st_d.wdog = io_req.wdata;
      end else if (io_req.addr == ADDR_SELFTEST_PROGRESS) begin
        st_d.selftest_progress = io_req.wdata;
      end else if (io_req.addr == ADDR_BID) begin
        st_d.bid = io_req.wdata;
      end else if (io_req.addr == ADDR_NET) begin
        st_d.net = io_req.wdata;
      end else if (io_req.addr == ADDR_VIDEO) begin
        st_d.video = io_req.wdata;
      end else if (io_req.addr == ADDR_HIDX) begin
        st_d.hidx = io_req.wdata;
      end else if (io_req.addr == ADDR_HDATA) begin
        st_d.hdata[st_q.hidx[HC_IDX_W-1:0]] = io_req.wdata;
      end else if (io_req.addr == ADDR_INT) begin
        // Only the mask half takes the write
        st_d.imask = io_req.wdata[INT_MASK_W-1:0];
      end else begin
        // Status, switch and unmapped writes fall here, ignored
        st_d.rack = io_req.rd;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Data entries have no defined value; cleared anyway for clean sims.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q       <= '0;
      st_q.flash <= RST_FLASH;
      st_q.imask <= RST_IMASK;
      st_q.wdog  <= RST_REG;
      st_q.hidx  <= RST_REG;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io_rdata   = st_q.rdata;
  assign io_rack    = st_q.rack;
  assign flash_page = st_q.flash[FL_PAGE_LSB +: FL_PAGE_W];
  // Override forces flash boot, otherwise the switch decides
  assign boot_from_flash = st_q.flash[FL_OVR_BIT] | sns.boot_sw;
  // Program and erase pulses pass only while enabled
  assign flash_we_n = flash_we_req_n | ~st_q.flash[FL_WE_BIT];

  always_comb begin
    ctl_out          = '0;
    ctl_out.wdog     = st_q.wdog;
    ctl_out.selftest_progress     = st_q.selftest_progress;
    ctl_out.board_identity = st_q.bid;
    ctl_out.net      = st_q.net;
    ctl_out.video    = st_q.video;
    ctl_out.hidx     = st_q.hidx;
    ctl_out.imask    = st_q.imask;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_flash_wr;
    io_req.wr && !io_req.rd && io_req.addr == ADDR_FLASH;
  endsequence

  sequence s_flash_rd;
    io_req.rd && !io_req.wr && io_req.addr == ADDR_FLASH;
  endsequence

  a_unmapped_float: assert property (
    (io_req.rd && !mapped) |=> (io_rack && io_rdata == RD_FLOAT))
    else $error("unmapped read did not float high");

  a_flash_clear: assert property (
    $fell(rst) |-> (st_q.flash == RST_FLASH && (!boot_from_flash || sns.boot_sw)))
    else $error("flash control not clear after reset");

  a_boot_override: assert property (
    boot_from_flash == (st_q.flash[FL_OVR_BIT] || sns.boot_sw))
    else $error("boot source select wrong");

  // A written override must win over the switch in the next cycle
  a_override_write: assert property (
    (io_req.wr && io_req.addr == ADDR_FLASH && io_req.wdata[FL_OVR_BIT]) |=> boot_from_flash)
    else $error("override write did not force flash boot");

  a_page_lines: assert property (
    s_flash_wr ##1 (!io_req.wr)[*2] |->
      flash_page == $past(io_req.wdata[FL_PAGE_LSB +: FL_PAGE_W], 2))
    else $error("flash page lines do not follow write");

  a_page_zero: assert property (
    $fell(rst) |-> flash_page == 3'h0)
    else $error("page not zero after reset");

  a_scratch_back: assert property (
    s_flash_wr ##1 !io_req.wr ##1 s_flash_rd |=>
      io_rdata[FL_SCR_BIT] == $past(io_req.wdata[FL_SCR_BIT], 3))
    else $error("scratch bit not read back");

  a_reserved_zero: assert property (
    (st_q.flash & ~FL_WMASK) == 8'h00)
    else $error("reserved flash bits set");

  a_status_live: assert property (
    (io_req.rd && io_req.addr == ADDR_STAT) |=> io_rdata == $past(stat_val))
    else $error("status read wrong");

  a_int_reset: assert property (
    $fell(rst) |-> st_q.imask == RST_IMASK ##1 (io_req.wr || st_q.imask == RST_IMASK))
    else $error("interrupt mask reset value wrong");

  a_hdata_index: assert property (
    (io_req.wr && io_req.addr == ADDR_HDATA) |=>
      st_q.hdata[st_q.hidx[HC_IDX_W-1:0]] == $past(io_req.wdata))
    else $error("host data not stored at index");

  a_we_gate: assert property (
    !flash_we_n |-> (st_q.flash[FL_WE_BIT] && !flash_we_req_n))
    else $error("flash write passed while disabled");

  a_selftest_progress_hidden: assert property (
    (io_req.wr && io_req.addr == ADDR_SELFTEST_PROGRESS) ##1 !io_req.wr
      ##1 (io_req.rd && io_req.addr == ADDR_SELFTEST_PROGRESS)
      |=> (io_rdata == 8'h00 && ctl_out.selftest_progress == $past(io_req.wdata, 3)))
    else $error("progress code visible on read or not latched");

endmodule

//--- tb/bsr_host.sv
// Host processor model issuing byte I/O read and write cycles
`timescale 1ns/1ps

module bsr_host (
  input  wire logic            ref_clk,  // System clock
  input  wire logic [7:0]      io_rdata, // Read data from the bank
  input  wire logic            io_rack,  // Read answer pulse
  output bsr_pkg::bsr_io_req_t io_req    // Cycle towards the bank
);
  import bsr_pkg::*;

  // ----------------------------------------------------------------
  // Bus idle at time zero
  // ----------------------------------------------------------------
  initial io_req = '0;

  // One write: strobe high for exactly one taken edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    io_req.wr    <= 1'b1;
    io_req.addr  <= a;
    io_req.wdata <= d;
    @(posedge ref_clk);
    io_req.wr    <= 1'b0;
    io_req.addr  <= ~a; // Released bus shows no stale address
    io_req.wdata <= ~d;
  endtask

  // One read: the answer lands one cycle after the taken edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic k);
    @(posedge ref_clk);
    io_req.rd   <= 1'b1;
    io_req.addr <= a;
    @(posedge ref_clk);
    io_req.rd   <= 1'b0;
    io_req.addr <= ~a;
    @(posedge ref_clk);
    d = io_rdata; // Registered answer, sampled before this edge lands
    k = io_rack;
  endtask
endmodule

//--- tb/bsr_top_tb.sv
// Self-checking testbench for the board system register bank
`timescale 1ns/1ps

module bsr_top_tb;
  import bsr_pkg::*;

  logic        ref_clk, rst, flash_we_req_n;  // Clock, reset, write request
  logic        io_rack, flash_we_n, boot_from_flash, k; // Design outputs
  logic [7:0]  io_rdata, d;                    // Read data
  logic [2:0]  flash_page;                     // Flash A24..A22
  bsr_io_req_t io_req;                         // Host cycle
  bsr_sense_t  sense_in;                       // Board pins
  bsr_ctl_t    ctl_out;                        // Control contents
  int          bad_count, compares;            // Tallies
  // Reset table, unmapped address last
  logic [15:0] ra [11] = '{ADDR_FLASH, ADDR_WDOG, ADDR_SELFTEST_PROGRESS, ADDR_STAT, ADDR_BID,
    ADDR_SWMON, ADDR_NET, ADDR_VIDEO, ADDR_HIDX, ADDR_INT, 16'h0081};
  logic [7:0]  rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h04, 8'hFF};
  logic [15:0] wa [5] = '{ADDR_WDOG, ADDR_BID, ADDR_NET, ADDR_VIDEO, ADDR_HIDX};

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100000; // Over fifty times the expected run
    bad_count++;
    end_of_test();
  end

  bsr_host host (.ref_clk(ref_clk), .io_rdata(io_rdata), .io_rack(io_rack),
    .io_req(io_req));
  bsr_top dut (.ref_clk(ref_clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
    .io_rack(io_rack), .sense_in(sense_in), .flash_we_req_n(flash_we_req_n),
    .flash_we_n(flash_we_n), .flash_page(flash_page),
    .boot_from_flash(boot_from_flash), .ctl_out(ctl_out));

  // ----------------------------------------------------------------
  // Checking tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read through the host and check both answer pulse and data
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    host.rd(a, d, k);
    chk("io_rack", 8'h01, {7'h00, k});
    chk($sformatf("rd %h", a), e, d);
  endtask
  task automatic pins(input logic [7:0] e); // Page, boot, gated write
    chk("pins", e, {flash_page, boot_from_flash, 3'h0, flash_we_n});
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    sense_in = '0;
    flash_we_req_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset values; write-only code reads zero; unmapped reads float
    for (int i = 0; i < 11; i++) rdchk(ra[i], rv[i]);
    pins(8'h01);
    chk("imask", 8'h04, {4'h0, ctl_out.imask});
    // Plain storage registers reach the control outputs
    for (int i = 0; i < 5; i++) begin
      host.wr(wa[i], 8'hA5 ^ i[7:0]);
      rdchk(wa[i], 8'hA5 ^ i[7:0]);
    end
    chk("wdog", 8'hA5, ctl_out.wdog);
    chk("bid", 8'hA4, ctl_out.board_identity);
    chk("net", 8'hA7, ctl_out.net);
    chk("video", 8'hA6, ctl_out.video);
    chk("hidx", 8'hA1, ctl_out.hidx);
    // Read-only places ignore writes; mask half only takes bits 3:0
    host.wr(ADDR_STAT, 8'hFF);
    host.wr(ADDR_SWMON, 8'hFF);
    host.wr(ADDR_INT, 8'hFF);
    host.wr(16'h0178, 8'hFF); // Alias of flash control must miss
    rdchk(ADDR_STAT, 8'h00);
    rdchk(ADDR_SWMON, 8'h00);
    rdchk(ADDR_INT, 8'h0F);
    rdchk(ADDR_FLASH, 8'h00);
    // Every held flash bit set, then the gated write path
    host.wr(ADDR_FLASH, 8'hF6);
    rdchk(ADDR_FLASH, 8'hF6);
    flash_we_req_n <= 1'b0;
    @(posedge ref_clk);
    pins(8'hF0);
    host.wr(ADDR_FLASH, 8'hFF); // Reserved bits written on purpose
    rdchk(ADDR_FLASH, 8'hF6);
    host.wr(ADDR_FLASH, 8'h04);
    rdchk(ADDR_FLASH, 8'h04);
    pins(8'h01);
    // Every page, switch selecting the board's default source
    for (int p = 0; p < 8; p++) begin
      host.wr(ADDR_FLASH, {1'b0, p[2:0], 4'h0});
      @(posedge ref_clk); // Let the write land before looking at the pins
      pins({p[2:0], 5'h01});
    end
    sense_in.boot_sw <= 1'b1;
    repeat (8) @(posedge ref_clk);
    pins(8'hF1);
    sense_in.boot_sw <= 1'b0;
    repeat (8) @(posedge ref_clk);
    pins(8'hE1);
    // Progress code latched but never read back
    host.wr(ADDR_SELFTEST_PROGRESS, 8'h5A);
    rdchk(ADDR_SELFTEST_PROGRESS, 8'h00);
    chk("selftest_progress", 8'h5A, ctl_out.selftest_progress);
    // Index low bits select the data entry
    host.wr(ADDR_HIDX, 8'h03);
    host.wr(ADDR_HDATA, 8'h33);
    host.wr(ADDR_HIDX, 8'h05);
    host.wr(ADDR_HDATA, 8'h55);
    host.wr(ADDR_HIDX, 8'h0B);
    rdchk(ADDR_HDATA, 8'h33);
    host.wr(ADDR_HIDX, 8'h05);
    rdchk(ADDR_HDATA, 8'h55);
    // Status pins through the synchroniser
    sense_in <= '{boot_sw: 1'b0, enum_state: 1'b1, wd_stage1: 1'b1, psu_ok: 1'b1,
      switches: 8'hA5, int_status: 4'h9};
    repeat (8) @(posedge ref_clk);
    rdchk(ADDR_STAT, 8'h07);
    rdchk(ADDR_SWMON, 8'hA5);
    rdchk(ADDR_INT, 8'h9F);
    // Second reset in mid-run
    host.wr(ADDR_FLASH, 8'hF6);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(ADDR_FLASH, 8'h00);
    pins(8'h01);
    rdchk(ADDR_INT, 8'h94);
    end_of_test();
  end
endmodule
